// ===== src/slot_flag_registers.sv
// Behaviour
// - Second offset delays channel two 0-255 clocks
// - Second offset used only in independent mode
// - Independent off: both channels use first offset
// - Independent on: each channel own offset
// - Swap bit exchanges left and right channels
// - Enable field: both, left, right, none
// - Early release bit resets to enabled
// - Sticky overflow: left, right, shifter bits
// - Sticky flags clear on read, refire freshly
// - Live overflow register mirrors same bits
// - Sticky noise flags for left and right
// - Sticky flags latch processor interrupt ports
// - Live register shows processor ports instantly
// - Live register shows noise state instantly
// - Repeating interrupt pulses until flag read
module slot_flag_registers
   import slot_flag_pkg::*;
#(
   parameter int HIGH_CYCLES  = PULSE_CYCLES,
   parameter int TOTAL_CYCLES = PERIOD_CYCLES
)
(
   input  wire logic          mclk,
   input  wire logic          reset,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_write,
   input  wire logic          reg_read,
   output logic [7:0]         reg_rdata,
   output logic               reg_rvalid,
   input  wire logic [7:0]    first_slot_offset,
   input  wire flag_source_t  flag_src,
   input  wire logic          channel_start,
   input  wire logic          channel_last_bit,
   input  wire logic          slot_end,
   output logic               sdata_oe_n,
   output slot_config_t       slot_cfg,
   input  wire logic          int_a_repeat,
   input  wire logic [1:0]    int_a_select,
   input  wire logic          int_b_repeat,
   input  wire logic [1:0]    int_b_select,
   output logic               interrupt_out_a,
   output logic               interrupt_out_b
);

   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------
   logic hit_offset;
   logic hit_control;
   logic hit_ovf_sticky;
   logic hit_ovf_live;
   logic hit_conv_sticky;
   logic hit_conv_live;
   logic wr_offset;
   logic wr_control;
   logic rd_ovf_sticky;
   logic rd_conv_sticky;

   assign hit_offset      = (reg_addr == ADDR_SECOND_SLOT_OFFSET);
   assign hit_control     = (reg_addr == ADDR_SERIAL_SLOT_CONTROL);
   assign hit_ovf_sticky  = (reg_addr == ADDR_OVERFLOW_FLAGS_STICKY);
   assign hit_ovf_live    = (reg_addr == ADDR_OVERFLOW_FLAGS_LIVE);
   assign hit_conv_sticky = (reg_addr == ADDR_CONVERTER_FLAGS_STICKY);
   assign hit_conv_live   = (reg_addr == ADDR_CONVERTER_FLAGS_LIVE);

   // Reserved and read-only addresses simply ignore writes
   assign wr_offset       = reg_write && hit_offset;
   assign wr_control      = reg_write && hit_control;
   assign rd_ovf_sticky   = reg_read && hit_ovf_sticky;
   assign rd_conv_sticky  = reg_read && hit_conv_sticky;

   // -------------------------------------------------------------------
   // Writable registers
   // -------------------------------------------------------------------
   logic [7:0] second_slot_offset;
   logic [7:0] serial_slot_control;
   logic [7:0] next_serial_slot_control;

   // Reserved upper bits are forced to their reset value, whatever is written
   assign next_serial_slot_control = (reg_wdata & SERIAL_SLOT_CONTROL_WMASK)
                                   | (SERIAL_SLOT_CONTROL_RESET & ~SERIAL_SLOT_CONTROL_WMASK);

   always_ff @(posedge mclk)
   begin
      if (reset)
         second_slot_offset <= SECOND_SLOT_OFFSET_RESET;
      else if (wr_offset)
         second_slot_offset <= reg_wdata;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         serial_slot_control <= SERIAL_SLOT_CONTROL_RESET;
      else if (wr_control)
         serial_slot_control <= next_serial_slot_control;
   end

   // -------------------------------------------------------------------
   // Control field decode
   // -------------------------------------------------------------------
   logic       independent_mode;
   logic       early_release;
   logic       channel_swap;
   logic [1:0] enable_field;
   logic       left_enable;
   logic       right_enable;
   logic [7:0] second_channel_offset;

   assign independent_mode = serial_slot_control[SLOT_INDEPENDENT_BIT];
   assign early_release    = serial_slot_control[EARLY_RELEASE_BIT];
   assign channel_swap     = serial_slot_control[CHANNEL_SWAP_BIT];
   assign enable_field     = serial_slot_control[CHANNEL_ENABLE_HI:CHANNEL_ENABLE_LO];

   assign left_enable  = (enable_field == ENABLE_BOTH) || (enable_field == ENABLE_LEFT);
   assign right_enable = (enable_field == ENABLE_BOTH) || (enable_field == ENABLE_RIGHT);

   // Second offset counts clocks after the first channel ends
   assign second_channel_offset = independent_mode ? second_slot_offset
                                                   : first_slot_offset;

   // -------------------------------------------------------------------
   // Slot configuration towards the serialiser
   // -------------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (reset)
         slot_cfg <= '0;
      else
      begin
         slot_cfg.channel_swap          <= channel_swap;
         slot_cfg.left_enable           <= left_enable;
         slot_cfg.right_enable          <= right_enable;
         slot_cfg.early_release         <= early_release;
         slot_cfg.second_relative       <= independent_mode;
         slot_cfg.first_channel_offset  <= first_slot_offset;
         slot_cfg.second_channel_offset <= second_channel_offset;
      end
   end

   // -------------------------------------------------------------------
   // Serial data output enable
   // -------------------------------------------------------------------
   // A new channel start wins over a release arriving in the same cycle,
   // so back-to-back channels never glitch the pin to high impedance.
   always_ff @(posedge mclk)
   begin
      if (reset)
         sdata_oe_n <= 1'b1;
      else if (channel_start)
         sdata_oe_n <= 1'b0;
      else if (early_release && channel_last_bit)
         sdata_oe_n <= 1'b1;
      else if (slot_end)
         sdata_oe_n <= 1'b1;
   end

   // -------------------------------------------------------------------
   // Flag sources
   // -------------------------------------------------------------------
   logic [7:0] ovf_src;
   logic [7:0] conv_src;
   logic [7:0] ovf_prev;
   logic [7:0] conv_prev;
   logic [7:0] ovf_rise;
   logic [7:0] conv_rise;

   always_comb
   begin
      ovf_src                  = BYTE_ZERO;
      ovf_src[OVF_LEFT_BIT]    = flag_src.ovf_left;
      ovf_src[OVF_RIGHT_BIT]   = flag_src.ovf_right;
      ovf_src[OVF_SHIFTER_BIT] = flag_src.ovf_shifter;
   end

   always_comb
   begin
      conv_src                    = BYTE_ZERO;
      conv_src[NOISE_LEFT_BIT]    = flag_src.noise_left;
      conv_src[NOISE_RIGHT_BIT]   = flag_src.noise_right;
      conv_src[DSP_STANDARD_BIT]  = flag_src.dsp_standard;
      conv_src[DSP_AUXILIARY_BIT] = flag_src.dsp_auxiliary;
   end

   // Only a fresh rising edge sets a sticky bit; a condition that is
   // still present after a read does not set it again.
   assign ovf_rise  = ovf_src & ~ovf_prev;
   assign conv_rise = conv_src & ~conv_prev;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         ovf_prev  <= BYTE_ZERO;
         conv_prev <= BYTE_ZERO;
      end
      else
      begin
         ovf_prev  <= ovf_src;
         conv_prev <= conv_src;
      end
   end

   // -------------------------------------------------------------------
   // Sticky and live flag registers
   // -------------------------------------------------------------------
   logic [7:0] overflow_flags_sticky;
   logic [7:0] converter_flags_sticky;
   logic [7:0] overflow_flags_live;
   logic [7:0] converter_flags_live;
   logic [7:0] next_overflow_sticky;
   logic [7:0] next_converter_sticky;

   // Set beats the clear of a read in the same cycle
   assign next_overflow_sticky  = ((rd_ovf_sticky ? BYTE_ZERO : overflow_flags_sticky)
                                  | ovf_rise) & OVERFLOW_MASK;
   assign next_converter_sticky = ((rd_conv_sticky ? BYTE_ZERO : converter_flags_sticky)
                                  | conv_rise) & (NOISE_MASK | DSP_PORT_MASK);

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         overflow_flags_sticky  <= BYTE_ZERO;
         converter_flags_sticky <= BYTE_ZERO;
      end
      else
      begin
         overflow_flags_sticky  <= next_overflow_sticky;
         converter_flags_sticky <= next_converter_sticky;
      end
   end

   // Live views read the source levels as they stand when sampled
   assign overflow_flags_live  = ovf_src & OVERFLOW_MASK;
   assign converter_flags_live = conv_src & (NOISE_MASK | DSP_PORT_MASK);

   // -------------------------------------------------------------------
   // Read data path
   // -------------------------------------------------------------------
   logic [7:0] read_select;

   // Reserved and unmapped addresses read as zero
   assign read_select = hit_offset      ? second_slot_offset     :
                        hit_control     ? serial_slot_control    :
                        hit_ovf_sticky  ? overflow_flags_sticky  :
                        hit_ovf_live    ? overflow_flags_live    :
                        hit_conv_sticky ? converter_flags_sticky :
                        hit_conv_live   ? converter_flags_live   :
                                          RESERVED_READ_VALUE;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         reg_rdata  <= BYTE_ZERO;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_read;
         if (reg_read)
            reg_rdata <= read_select;
      end
   end

   // -------------------------------------------------------------------
   // Interrupt pulse outputs
   // -------------------------------------------------------------------
   logic noise_event;
   logic engine_event;
   logic flag_read;
   logic trigger_a;
   logic trigger_b;

   assign noise_event  = |(conv_rise & NOISE_MASK);
   assign engine_event = (|(ovf_rise & OVERFLOW_MASK)) || (|(conv_rise & DSP_PORT_MASK));
   assign flag_read    = rd_ovf_sticky || rd_conv_sticky;
   assign trigger_a    = (int_a_select[0] && noise_event) || (int_a_select[1] && engine_event);
   assign trigger_b    = (int_b_select[0] && noise_event) || (int_b_select[1] && engine_event);

   interrupt_pulser #(
      .HIGH_CYCLES  (HIGH_CYCLES),
      .TOTAL_CYCLES (TOTAL_CYCLES)
   ) pulser_a (
      .mclk        (mclk),
      .reset       (reset),
      .trigger     (trigger_a),
      .repeat_mode (int_a_repeat),
      .stop        (flag_read),
      .pulse       (interrupt_out_a)
   );

   interrupt_pulser #(
      .HIGH_CYCLES  (HIGH_CYCLES),
      .TOTAL_CYCLES (TOTAL_CYCLES)
   ) pulser_b (
      .mclk        (mclk),
      .reset       (reset),
      .trigger     (trigger_b),
      .repeat_mode (int_b_repeat),
      .stop        (flag_read),
      .pulse       (interrupt_out_b)
   );

endmodule

// ===== common/slot_flag_pkg.sv
package slot_flag_pkg;

   // -------------------------------------------------------------------
   // Register addresses
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_SECOND_SLOT_OFFSET    = 8'h25;
   localparam logic [7:0] ADDR_SERIAL_SLOT_CONTROL   = 8'h26;
   localparam logic [7:0] ADDR_RESERVED_BLOCK_A0     = 8'h27;
   localparam logic [7:0] ADDR_RESERVED_BLOCK_A1     = 8'h28;
   localparam logic [7:0] ADDR_RESERVED_BLOCK_A2     = 8'h29;
   localparam logic [7:0] ADDR_OVERFLOW_FLAGS_STICKY = 8'h2a;
   localparam logic [7:0] ADDR_OVERFLOW_FLAGS_LIVE   = 8'h2b;
   localparam logic [7:0] ADDR_RESERVED_BLOCK_B      = 8'h2c;
   localparam logic [7:0] ADDR_CONVERTER_FLAGS_STICKY = 8'h2d;
   localparam logic [7:0] ADDR_RESERVED_BLOCK_C      = 8'h2e;
   localparam logic [7:0] ADDR_CONVERTER_FLAGS_LIVE  = 8'h2f;

   // -------------------------------------------------------------------
   // Reset values and masks
   // -------------------------------------------------------------------
   localparam logic [7:0] SECOND_SLOT_OFFSET_RESET  = 8'h00;
   localparam logic [7:0] SERIAL_SLOT_CONTROL_RESET = 8'h02;
   localparam logic [7:0] SERIAL_SLOT_CONTROL_WMASK = 8'h1f;
   localparam logic [7:0] OVERFLOW_MASK             = 8'h0e;
   localparam logic [7:0] NOISE_MASK                = 8'h60;
   localparam logic [7:0] DSP_PORT_MASK             = 8'h18;
   localparam logic [7:0] BYTE_ZERO                 = 8'h00;
   localparam logic [7:0] RESERVED_READ_VALUE       = 8'h00;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int SLOT_INDEPENDENT_BIT = 0;
   localparam int EARLY_RELEASE_BIT    = 1;
   localparam int CHANNEL_ENABLE_LO    = 2;
   localparam int CHANNEL_ENABLE_HI    = 3;
   localparam int CHANNEL_SWAP_BIT     = 4;
   localparam int OVF_LEFT_BIT         = 3;
   localparam int OVF_RIGHT_BIT        = 2;
   localparam int OVF_SHIFTER_BIT      = 1;
   localparam int NOISE_LEFT_BIT       = 6;
   localparam int NOISE_RIGHT_BIT      = 5;
   localparam int DSP_STANDARD_BIT     = 4;
   localparam int DSP_AUXILIARY_BIT    = 3;

   // Channel enable field codes
   localparam logic [1:0] ENABLE_BOTH  = 2'h0;
   localparam logic [1:0] ENABLE_LEFT  = 2'h1;
   localparam logic [1:0] ENABLE_RIGHT = 2'h2;
   localparam logic [1:0] ENABLE_NONE  = 2'h3;

   // -------------------------------------------------------------------
   // Interrupt pulse timing
   // -------------------------------------------------------------------
   localparam int CLOCK_MHZ       = 200;
   localparam int PULSE_WIDTH_US  = 2000;
   localparam int PULSE_PERIOD_US = 4000;
   localparam int PULSE_CYCLES    = PULSE_WIDTH_US * CLOCK_MHZ;
   localparam int PERIOD_CYCLES   = PULSE_PERIOD_US * CLOCK_MHZ;
   localparam int PULSE_COUNT_W   = 20;

   // -------------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic       ovf_left;
      logic       ovf_right;
      logic       ovf_shifter;
      logic       noise_left;
      logic       noise_right;
      logic       dsp_standard;
      logic       dsp_auxiliary;
   } flag_source_t;

   typedef struct packed {
      logic       channel_swap;
      logic       left_enable;
      logic       right_enable;
      logic       early_release;
      logic       second_relative;
      logic [7:0] first_channel_offset;
      logic [7:0] second_channel_offset;
   } slot_config_t;

   typedef enum logic [1:0] {
      PULSE_IDLE,
      PULSE_HIGH,
      PULSE_LOW
   } pulse_state_t;

endpackage

// ===== src/interrupt_pulser.sv
module interrupt_pulser
   import slot_flag_pkg::*;
#(
   parameter int HIGH_CYCLES  = PULSE_CYCLES,
   parameter int TOTAL_CYCLES = PERIOD_CYCLES
)
(
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic trigger,
   input  wire logic repeat_mode,
   input  wire logic stop,
   output logic      pulse
);

   localparam logic [PULSE_COUNT_W-1:0] HIGH_LAST = PULSE_COUNT_W'(HIGH_CYCLES - 1);
   localparam logic [PULSE_COUNT_W-1:0] LOW_LAST  = PULSE_COUNT_W'(TOTAL_CYCLES - HIGH_CYCLES - 1);
   localparam logic [PULSE_COUNT_W-1:0] COUNT_ONE = PULSE_COUNT_W'(1);

   pulse_state_t             state;
   pulse_state_t             next_state;
   logic [PULSE_COUNT_W-1:0] count;
   logic                     keep_going;
   logic                     high_done;
   logic                     low_done;

   assign high_done = (state == PULSE_HIGH) && (count == HIGH_LAST);
   assign low_done  = (state == PULSE_LOW) && (count == LOW_LAST);

   // A fresh trigger restarts repetition even in the cycle of a stopping read, unless that cycle ends a high phase
   always_ff @(posedge mclk)
   begin
      if (reset)
         keep_going <= 1'b0;
      else if (trigger)
         keep_going <= 1'b1;
      else if (stop)
         keep_going <= 1'b0;
   end

   always_comb
   begin
      next_state = state;
      unique case (state)
         PULSE_IDLE:
            if (trigger)
               next_state = PULSE_HIGH;
         PULSE_HIGH:
            if (high_done)
               next_state = (repeat_mode && keep_going && !stop) ? PULSE_LOW : PULSE_IDLE;
         PULSE_LOW:
            if (stop && !trigger)
               next_state = PULSE_IDLE;
            else if (low_done)
               next_state = PULSE_HIGH;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state <= PULSE_IDLE;
         count <= '0;
         pulse <= 1'b0;
      end
      else
      begin
         state <= next_state;
         count <= (next_state != state) ? '0 : count + COUNT_ONE;
         pulse <= (next_state == PULSE_HIGH);
      end
   end

endmodule

// ===== dv/slot_flag_monitor.sv
module slot_flag_monitor
   import slot_flag_pkg::*;
(
   input wire logic         mclk,
   input wire logic         reset,
   input wire logic [7:0]   reg_addr,
   input wire logic [7:0]   reg_wdata,
   input wire logic         reg_write,
   input wire logic         reg_read,
   input wire logic [7:0]   reg_rdata,
   input wire logic         reg_rvalid,
   input wire logic [7:0]   first_slot_offset,
   input wire flag_source_t flag_src,
   input wire logic         channel_start,
   input wire logic         channel_last_bit,
   input wire logic         slot_end,
   input wire logic         sdata_oe_n,
   input wire slot_config_t slot_cfg
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Register port and slot output checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   wire rsvd_addr = reg_addr inside {8'h27, 8'h28, 8'h29, 8'h2c, 8'h2e};

   AST_READ_ANSWER: assert property (reg_read |=> reg_rvalid)
      else $error("read not answered");
   AST_NO_SPURIOUS: assert property (!reg_read |=> !reg_rvalid)
      else $error("answer without read");
   AST_RESERVED_ZERO: assert property (reg_read && rsvd_addr |=> reg_rdata == 8'h00)
      else $error("reserved read not zero");
   AST_LIVE_CONV: assert property (reg_read && reg_addr == 8'h2f |=>
      reg_rdata == {1'b0, $past(flag_src[3:0]), 3'h0})
      else $error("live converter flags wrong");
   AST_LIVE_OVF: assert property (reg_read && reg_addr == 8'h2b |=>
      reg_rdata == {4'h0, $past(flag_src[6:4]), 1'b0})
      else $error("live overflow flags wrong");
   AST_OE_START: assert property (channel_start |=> !sdata_oe_n)
      else $error("data pin not driven after start");
   AST_OE_EARLY: assert property (channel_last_bit && slot_cfg.early_release
      && !channel_start |=> sdata_oe_n)
      else $error("early release missed");
   AST_OE_HOLD: assert property (channel_last_bit && !slot_cfg.early_release
      && !channel_start && !slot_end |=> $stable(sdata_oe_n))
      else $error("released without early release");
   AST_CTRL_WRITE: assert property (reg_write && reg_addr == 8'h26 |=> ##1
      slot_cfg.channel_swap == $past(reg_wdata[4], 2)
      && slot_cfg.left_enable == !$past(reg_wdata[3], 2)
      && slot_cfg.right_enable == !$past(reg_wdata[2], 2))
      else $error("control write not applied");
   AST_FIRST_OFFSET: assert property (!$past(reset) && !slot_cfg.second_relative |->
      slot_cfg.second_channel_offset == $past(first_slot_offset)
      && slot_cfg.first_channel_offset == $past(first_slot_offset))
      else $error("shared offset wrong");
endmodule

// ===== dv/slot_flag_registers_tb.sv
module slot_flag_registers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import slot_flag_pkg::*;
   logic         mclk = 0, reset = 1, reg_write = 0, reg_read = 0;
   logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, first_slot_offset = 8'h3c;
   logic         reg_rvalid, channel_start = 0, channel_last_bit = 0, slot_end = 0;
   logic         sdata_oe_n, int_a_repeat = 0, int_b_repeat = 0, irq_a, irq_b;
   logic [1:0]   int_a_select = 2'h0, int_b_select = 2'h0;
   flag_source_t src = '0;
   slot_config_t cfg;
   int           n_errors = 0, compares = 0, n;
   logic [7:0]   d;
   logic [7:0]   rsvd_list [6] = '{8'h27, 8'h28, 8'h29, 8'h2c, 8'h2e, 8'h2a};

   slot_flag_registers #(.HIGH_CYCLES(4), .TOTAL_CYCLES(10)) dut (.mclk(mclk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .first_slot_offset(first_slot_offset),
      .flag_src(src), .channel_start(channel_start), .channel_last_bit(channel_last_bit),
      .slot_end(slot_end), .sdata_oe_n(sdata_oe_n), .slot_cfg(cfg),
      .int_a_repeat(int_a_repeat), .int_a_select(int_a_select), .int_b_repeat(int_b_repeat),
      .int_b_select(int_b_select), .interrupt_out_a(irq_a), .interrupt_out_b(irq_b));

   always #2.5 mclk = ~mclk;
   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = v;
      reg_write = 1;
      @(negedge mclk);
      reg_write = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk);
      reg_addr = a;
      reg_read = 1;
      @(negedge mclk);
      reg_read = 0;
      chk("rvalid", 8'h01, {7'h0, reg_rvalid});
      chk($sformatf("register %h", a), exp, reg_rdata);
   endtask
   task automatic pulse(input int k, input logic exp);
      @(negedge mclk);
      {channel_start, channel_last_bit, slot_end} = 3'h4 >> k;
      @(negedge mclk);
      {channel_start, channel_last_bit, slot_end} = 3'h0;
      chk("oe_n", {7'h0, exp}, {7'h0, sdata_oe_n});
   endtask
   // Cap of 40 marks a level that never ends
   task automatic run_len(input bit b, input logic lvl, output int c);
      c = 0;
      while (((b ? irq_b : irq_a) === lvl) && c < 40)
      begin
         @(negedge mclk);
         c++;
      end
   endtask
   task automatic settle(input flag_source_t s);
      @(negedge mclk);
      src = s;
      repeat (2) @(negedge mclk);
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      #50000;
      n_errors++;
      $display("watchdog expired");
      conclude();
   end

   initial
   begin
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      reset = 0;
      rd(8'h25, 8'h00);
      rd(8'h26, 8'h02);
      rd(8'h2a, 8'h00);
      rd(8'h2d, 8'h00);
      chk("early", 8'h01, {7'h0, cfg.early_release});
      $display("test reset done");
      wr(8'h25, 8'ha5);
      wr(8'h26, 8'h1f);
      rd(8'h26, 8'h1f);
      rd(8'h25, 8'ha5);
      for (int c = 0; c < 4; c++)
      begin
         d = {3'h0, c[0], c[1:0], 1'b1, c[1]};
         wr(8'h26, d);
         @(negedge mclk);
         chk("swap", {7'h0, c[0]}, {7'h0, cfg.channel_swap});
         chk("enables", {6'h0, ~c[1], ~c[0]}, {6'h0, cfg.left_enable, cfg.right_enable});
         chk("second", c[1] ? 8'ha5 : 8'h3c, cfg.second_channel_offset);
         chk("first", 8'h3c, cfg.first_channel_offset);
      end
      $display("test control done");
      // Read-only 8'h2a is written first and must still read zero; reserved registers are only read
      wr(8'h2a, 8'h0e);
      foreach (rsvd_list[i])
         rd(rsvd_list[i], 8'h00);
      $display("test reserved done");
      settle(7'h50);
      rd(8'h2a, 8'h0a);
      rd(8'h2a, 8'h00);
      rd(8'h2b, 8'h0a);
      settle(7'h00);
      rd(8'h2b, 8'h00);
      settle(7'h20);
      rd(8'h2a, 8'h04);
      settle(7'h09);
      rd(8'h2d, 8'h48);
      rd(8'h2f, 8'h48);
      rd(8'h2d, 8'h00);
      settle(7'h06);
      rd(8'h2f, 8'h30);
      rd(8'h2d, 8'h30);
      settle(7'h00);
      $display("test flags done");
      wr(8'h26, 8'h02);
      pulse(0, 1'b0);
      pulse(1, 1'b1);
      wr(8'h26, 8'h00);
      pulse(0, 1'b0);
      pulse(1, 1'b0);
      pulse(2, 1'b1);
      $display("test output enable done");
      int_b_select = 2'h1;
      @(negedge mclk);
      src = 7'h08;
      run_len(1, 0, n);
      chk("latency b", 8'h01, n[7:0]);
      run_len(1, 1, n);
      chk("single high", 8'h04, n[7:0]);
      run_len(1, 0, n);
      chk("single after", 8'h28, n[7:0]);
      int_a_select = 2'h2;
      int_a_repeat = 1;
      @(negedge mclk);
      src = 7'h42;
      run_len(0, 0, n);
      chk("latency a", 8'h01, n[7:0]);
      run_len(0, 1, n);
      chk("repeat high", 8'h04, n[7:0]);
      run_len(0, 0, n);
      chk("repeat low", 8'h06, n[7:0]);
      rd(8'h2a, 8'h08);
      run_len(0, 1, n);
      run_len(0, 0, n);
      chk("after stop", 8'h28, n[7:0]);
      $display("test interrupts done");
      conclude();
   end
endmodule

bind slot_flag_registers slot_flag_monitor mon (.mclk(mclk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .first_slot_offset(first_slot_offset),
   .flag_src(flag_src), .channel_start(channel_start), .channel_last_bit(channel_last_bit),
   .slot_end(slot_end), .sdata_oe_n(sdata_oe_n), .slot_cfg(slot_cfg));
